// ### design/sffc_pkg.sv
package sffc_pkg;
	localparam int NUM_CH = 2;
	localparam int MON_W = 8;
	// Monitor bit positions
	localparam int MON_VDD_FAIL = 0;
	localparam int MON_VDD_POR = 1;
	localparam int MON_PWR_POR = 2;
	localparam int MON_PWR_UV = 3;
	localparam int MON_PWR_OV = 4;
	localparam int MON_PWR_REV = 5;
	localparam int MON_GND_LOST = 6;
	localparam int MON_SYS_GND_LOST = 7;
	localparam int FILT_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int FILT_CYCLES = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_CNT_W = 6;
	localparam logic [MON_W-1:0] MON_RESET = 8'h00;
	localparam int POR_FLAG_BIT = 6;
	// Status bit positions
	localparam int STAT_VDD_FAIL = 0;
	localparam int STAT_SYS_GND = 1;
	localparam int STAT_GND = 2;
	localparam int STAT_PWR_UV = 3;
	localparam int STAT_PWR_OV = 4;
	localparam int STAT_PWR_REV = 5;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [1:0] RETRY_RESET = 2'h0;
	localparam logic [3:0] RETRY_CNT_RESET = 4'h0;
	typedef enum logic [2:0] {
		MODE_SLEEP = 3'b001,
		MODE_NORMAL = 3'b010,
		MODE_FAILSAFE = 3'b100
	} sffc_mode_type;
endpackage : sffc_pkg

// ### design/sffc_mon_filter.sv
`timescale 1ns/1ps
module sffc_mon_filter
	import sffc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw comparator and filtered level
	input wire logic raw,
	output logic filt
);
	logic meta_q;
	logic sync_q;
	logic [FILT_CNT_W-1:0] cnt_q;
	logic filt_q;

	// Two-flop synchroniser; first flop feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end

	// Level must hold for the filter time before it is believed
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			filt_q <= 1'b0;
		end else if (sync_q == filt_q) begin
			cnt_q <= '0;
		end else if (cnt_q == FILT_CNT_W'(FILT_CYCLES - 1)) begin
			cnt_q <= '0;
			filt_q <= sync_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign filt = filt_q;
endmodule : sffc_mon_filter

// ### design/sffc_edge_sync.sv
`timescale 1ns/1ps
module sffc_edge_sync
	import sffc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level in, registered level and rising pulse out
	input wire logic din,
	output logic level,
	output logic rise
);
	logic prev_q;
	logic rise_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			prev_q <= din;
			rise_q <= din & ~prev_q;
		end
	end

	assign level = prev_q;
	assign rise = rise_q;
endmodule : sffc_edge_sync

// ### design/sffc_top.sv
`timescale 1ns/1ps
module sffc_top
	import sffc_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Raw supply and ground monitor comparators
	input wire logic [MON_W-1:0] MON_RAW,
	// Host side
	input wire logic RESET_WAKE_LOW_INPUT,
	input wire logic [NUM_CH-1:0] DIRECT_IN,
	input wire logic VDD_FAIL_EN,
	input wire logic [NUM_CH-1:0] SPI_CH_ON,
	input wire logic SPI_SO_DATA,
	input wire logic SPI_SO_EN,
	input wire logic CURRENT_SENSE_OUTPUT_REQ,
	// Channel analog monitors
	input wire logic [NUM_CH-1:0] NEG_CLAMP_HIT,
	input wire logic [NUM_CH-1:0] LOAD_GND_LOST,
	input wire logic [NUM_CH-1:0] PROT_FAULT,
	input wire logic [NUM_CH-1:0] OPENLOAD_RAW,
	// Retry counters from channel logic
	input wire logic [NUM_CH*4-1:0] RETRY_CNT_IN,
	// Outputs
	output logic [NUM_CH-1:0] HIGH_SIDE_OUTPUTS,
	output logic FAULT_STATUS_LOW_PIN,
	output logic FAILSAFE_OUTPUT_LOW_PIN,
	output logic SO_DATA_OUT,
	output logic SO_DATA_OE,
	output logic CURRENT_SENSE_EN,
	output logic SPI_ENABLE,
	output logic REG_RESET,
	output logic RETRY_CLEAR,
	output logic [NUM_CH-1:0] OPENLOAD_FLAG,
	output logic [7:0] STATUS_REGISTER,
	output logic [NUM_CH*4-1:0] RETRY_CNT_OUT,
	output logic [2:0] MODE_OUT
);
	logic [MON_W-1:0] mon;
	logic vdd_ok;
	logic vdd_por;
	logic pwr_por;
	logic pwr_uv;
	logic pwr_ov;
	logic pwr_rev;
	logic gnd_lost;
	logic sys_gnd_lost;
	logic wake_lvl;
	logic wake_rise;
	logic vdd_por_lvl;
	logic vdd_por_rise;
	logic pwr_por_lvl;
	logic pwr_por_rise;
	logic vdd_fail_lvl;
	logic vdd_fail_rise;
	logic gnd_lvl;
	logic gnd_rise;
	logic wake_src;
	logic fs_vdd_lost;
	logic fs_enter;
	logic por_now;
	logic [NUM_CH-1:0] ch_d;
	sffc_mode_type mode_q;
	sffc_mode_type mode_d;
	logic fen_q;
	logic fs_vdd_q;
	logic pwr_was_low_q;
	logic por_flag_q;
	logic [NUM_CH-1:0] hs_q;
	logic fault_low_q;
	logic fs_low_q;
	logic so_q;
	logic so_oe_q;
	logic current_sense_output_q;
	logic spi_en_q;
	logic reg_rst_q;
	logic retry_clr_q;
	logic [NUM_CH-1:0] ol_q;
	logic [7:0] stat_q;
	logic [7:0] stat_d;
	logic [NUM_CH*4-1:0] rcnt_q;

	// Every monitor gets its own synchroniser and glitch filter
	genvar gi;
	generate
		for (gi = 0; gi < MON_W; gi++) begin : g_mon
			sffc_mon_filter u_filt (
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.raw(MON_RAW[gi]),
				.filt(mon[gi])
			);
		end
	endgenerate

	assign vdd_ok = ~mon[MON_VDD_FAIL];
	assign vdd_por = mon[MON_VDD_POR];
	assign pwr_por = mon[MON_PWR_POR];
	assign pwr_uv = mon[MON_PWR_UV];
	assign pwr_ov = mon[MON_PWR_OV];
	assign pwr_rev = mon[MON_PWR_REV];
	assign gnd_lost = mon[MON_GND_LOST];
	assign sys_gnd_lost = mon[MON_SYS_GND_LOST];
	assign wake_src = RESET_WAKE_LOW_INPUT | (|DIRECT_IN);

	sffc_edge_sync u_wake (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(wake_src),
		.level(wake_lvl),
		.rise(wake_rise)
	);
	sffc_edge_sync u_vdd_por (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(vdd_por),
		.level(vdd_por_lvl),
		.rise(vdd_por_rise)
	);
	sffc_edge_sync u_pwr_por (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(pwr_por),
		.level(pwr_por_lvl),
		.rise(pwr_por_rise)
	);
	sffc_edge_sync u_vdd_fail (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(mon[MON_VDD_FAIL]),
		.level(vdd_fail_lvl),
		.rise(vdd_fail_rise)
	);
	sffc_edge_sync u_gnd (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(gnd_lost),
		.level(gnd_lvl),
		.rise(gnd_rise)
	);

	// Enable is sampled while logic supply is good, so a late clear cannot race the loss
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			fen_q <= 1'b0;
		end else if (vdd_ok && !vdd_fail_lvl) begin
			fen_q <= VDD_FAIL_EN;
		end
	end

	assign fs_vdd_lost = vdd_fail_rise & fen_q;
	assign fs_enter = fs_vdd_lost | gnd_rise;

	// Remember that power supply was low while logic supply also low
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			pwr_was_low_q <= 1'b0;
		end else if (!pwr_por_lvl) begin
			pwr_was_low_q <= ~vdd_por_lvl;
		end
	end

	// Supply-driven reset only when the other supply stays down throughout
	always_comb begin
		por_now = 1'b0;
		if (wake_lvl) begin
			if (pwr_por_rise && pwr_was_low_q && !vdd_por_lvl && !vdd_por) begin
				por_now = 1'b1;
			end
			if (vdd_por_rise && !pwr_por_lvl && !pwr_por) begin
				por_now = 1'b1;
			end
		end
		if (wake_rise && (pwr_por_lvl || vdd_por_lvl)) begin
			por_now = 1'b1;
		end
	end

	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			MODE_SLEEP: begin
				if (wake_lvl) begin
					mode_d = MODE_NORMAL;
				end
			end
			MODE_NORMAL: begin
				if (fs_enter) begin
					mode_d = MODE_FAILSAFE;
				end else if (!wake_lvl) begin
					mode_d = MODE_SLEEP;
				end
			end
			MODE_FAILSAFE: begin
				if (!wake_lvl) begin
					mode_d = MODE_SLEEP;
				end else if (vdd_ok && !gnd_lost && por_now) begin
					mode_d = MODE_NORMAL;
				end
			end
			default: mode_d = MODE_SLEEP;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			mode_q <= MODE_SLEEP;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Cause of fail-safe kept so ground-loss fail-safe is told apart
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			fs_vdd_q <= 1'b0;
		end else if (fs_vdd_lost) begin
			fs_vdd_q <= 1'b1;
		end else if (mode_d != MODE_FAILSAFE) begin
			fs_vdd_q <= 1'b0;
		end
	end

	// Register file reset pulse
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			reg_rst_q <= 1'b1;
			retry_clr_q <= 1'b1;
		end else begin
			reg_rst_q <= fs_vdd_lost | por_now;
			retry_clr_q <= fs_enter | por_now;
		end
	end

	// Retry counters pass through, cleared on fail-safe entry
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			rcnt_q <= '0;
		end else if (fs_enter || por_now) begin
			rcnt_q <= {NUM_CH{RETRY_CNT_RESET}};
		end else begin
			rcnt_q <= RETRY_CNT_IN;
		end
	end

	// POR flag: hardware set wins over register reset
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			por_flag_q <= 1'b1;
		end else if (por_now) begin
			por_flag_q <= 1'b1;
		end else if (fs_vdd_lost) begin
			por_flag_q <= 1'b0;
		end
	end

	// Channel drive; protective overrides rank above mode
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			always_comb begin
				ch_d[gi] = 1'b0;
				if (mode_q == MODE_FAILSAFE) begin
					if (!fs_vdd_q || (!pwr_uv && !pwr_ov)) begin
						ch_d[gi] = DIRECT_IN[gi];
					end
				end else if (mode_q == MODE_NORMAL) begin
					ch_d[gi] = SPI_CH_ON[gi];
				end
				if (sys_gnd_lost) begin
					ch_d[gi] = 1'b0;
				end
				if (NEG_CLAMP_HIT[gi] && !gnd_lost) begin
					ch_d[gi] = 1'b1;
				end
				if (pwr_rev) begin
					ch_d[gi] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			hs_q <= '0;
			ol_q <= '0;
		end else begin
			hs_q <= ch_d;
			ol_q <= OPENLOAD_RAW | LOAD_GND_LOST;
		end
	end

	// Fault pin works from the power supply side, independent of logic supply
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			fault_low_q <= 1'b1;
			fs_low_q <= 1'b1;
		end else begin
			fault_low_q <= ~(|PROT_FAULT | |OPENLOAD_RAW | |LOAD_GND_LOST);
			fs_low_q <= ~(mode_d == MODE_FAILSAFE);
		end
	end

	// Serial port stays up across power supply faults, down without logic supply
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			spi_en_q <= 1'b0;
			so_q <= 1'b0;
			so_oe_q <= 1'b0;
			current_sense_output_q <= 1'b0;
		end else begin
			spi_en_q <= vdd_ok && !gnd_lost && wake_lvl;
			so_q <= vdd_ok ? SPI_SO_DATA : 1'b0;
			so_oe_q <= vdd_ok && !gnd_lost && SPI_SO_EN;
			current_sense_output_q <= vdd_ok && CURRENT_SENSE_OUTPUT_REQ;
		end
	end

	// Status bits placed by name; reset flag includes a POR landing this cycle
	always_comb begin
		stat_d = STAT_RESET;
		stat_d[STAT_VDD_FAIL] = ~vdd_ok;
		stat_d[STAT_SYS_GND] = sys_gnd_lost;
		stat_d[STAT_GND] = gnd_lost;
		stat_d[STAT_PWR_UV] = pwr_uv;
		stat_d[STAT_PWR_OV] = pwr_ov;
		stat_d[STAT_PWR_REV] = pwr_rev;
		stat_d[POR_FLAG_BIT] = por_now | por_flag_q;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			stat_q <= STAT_RESET;
		end else begin
			stat_q <= stat_d;
		end
	end

	assign HIGH_SIDE_OUTPUTS = hs_q;
	assign FAULT_STATUS_LOW_PIN = fault_low_q;
	assign FAILSAFE_OUTPUT_LOW_PIN = fs_low_q;
	assign SO_DATA_OUT = so_q;
	assign SO_DATA_OE = so_oe_q;
	assign CURRENT_SENSE_EN = current_sense_output_q;
	assign SPI_ENABLE = spi_en_q;
	assign REG_RESET = reg_rst_q;
	assign RETRY_CLEAR = retry_clr_q;
	assign OPENLOAD_FLAG = ol_q;
	assign STATUS_REGISTER = stat_q;
	assign RETRY_CNT_OUT = rcnt_q;
	assign MODE_OUT = mode_q;
endmodule : sffc_top

// ### dv/sffc_host_model.sv
`timescale 1ns/1ps
module sffc_host_model (
	// Clock
	input wire logic clk,
	// Requests from the bench
	input wire logic wake_req,
	input wire logic pwr_uv,
	// Wake line to the device
	output logic wake
);
	logic uv_q = 1'h0;
	logic [1:0] gap_q = 2'h0;
	initial wake = 1'h1;
	always @(posedge clk) begin
		uv_q <= pwr_uv;
		// Short low pulse on recovery acts as the reset sequence
		if (uv_q && !pwr_uv) begin
			gap_q <= 2'h3;
		end else if (gap_q != 2'h0) begin
			gap_q <= gap_q - 2'h1;
		end
		wake <= #2 (wake_req || pwr_uv) && gap_q == 2'h0;
	end
endmodule : sffc_host_model

// ### dv/sffc_top_props.sv
`timescale 1ns/1ps
module sffc_top_props
	import sffc_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Inputs
	input wire logic [MON_W-1:0] MON_RAW,
	input wire logic VDD_FAIL_EN,
	input wire logic [NUM_CH-1:0] DIRECT_IN,
	input wire logic [NUM_CH-1:0] NEG_CLAMP_HIT,
	input wire logic [NUM_CH-1:0] LOAD_GND_LOST,
	input wire logic [NUM_CH-1:0] PROT_FAULT,
	input wire logic [NUM_CH-1:0] OPENLOAD_RAW,
	// Outputs
	input wire logic [NUM_CH-1:0] HIGH_SIDE_OUTPUTS,
	input wire logic FAULT_STATUS_LOW_PIN,
	input wire logic SO_DATA_OE,
	input wire logic CURRENT_SENSE_EN,
	input wire logic REG_RESET,
	input wire logic RETRY_CLEAR,
	input wire logic [NUM_CH-1:0] OPENLOAD_FLAG,
	input wire logic [NUM_CH*4-1:0] RETRY_CNT_OUT,
	input wire logic [2:0] MODE_OUT
);
	// Raw run lengths; sync plus filter settles well before 60
	logic [7:0] vdd_run_q;
	logic [7:0] gnd_run_q;
	logic en_q;
	logic fs;
	assign fs = MODE_OUT == MODE_FAILSAFE;
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !MON_RAW[MON_VDD_FAIL]) vdd_run_q <= 8'h00;
		else if (vdd_run_q != 8'hff) vdd_run_q <= vdd_run_q + 8'h01;
	end
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !MON_RAW[MON_SYS_GND_LOST]) gnd_run_q <= 8'h00;
		else if (gnd_run_q != 8'hff) gnd_run_q <= gnd_run_q + 8'h01;
	end
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) en_q <= 1'h0;
		else if (!MON_RAW[MON_VDD_FAIL]) en_q <= VDD_FAIL_EN;
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	a_vdd_fs_entry:
	assert property (vdd_run_q == 8'h3c && en_q |-> fs) else $error("no fail-safe on vdd loss");
	a_vdd_no_fs:
	assert property (vdd_run_q == 8'h3c && !en_q |-> !fs) else $error("fail-safe with enable clear");
	a_so_sense_dead:
	assert property (vdd_run_q >= 8'h3c |-> !SO_DATA_OE && !CURRENT_SENSE_EN)
		else $error("serial out or sense alive without vdd");
	a_fs_reg_reset:
	assert property (fs && !$past(fs) && MON_RAW[MON_VDD_FAIL]
		|-> REG_RESET || $past(REG_RESET) || $past(REG_RESET, 2)) else $error("no register reset");
	a_fs_retry_clear:
	assert property (fs && !$past(fs) |-> RETRY_CLEAR || $past(RETRY_CLEAR) || $past(RETRY_CLEAR, 2))
		else $error("no retry clear");
	a_fs_direct_in:
	assert property (vdd_run_q >= 8'h3c && fs && $past(fs, 2) && MON_RAW[5:3] == 3'h0
		&& !MON_RAW[MON_SYS_GND_LOST] && NEG_CLAMP_HIT == 2'h0 && PROT_FAULT == 2'h0
		&& $past(PROT_FAULT) == 2'h0 && $stable(DIRECT_IN) && $past(DIRECT_IN) == $past(DIRECT_IN, 2)
		|-> HIGH_SIDE_OUTPUTS == DIRECT_IN) else $error("channels not following direct inputs");
	a_fault_pin_low:
	assert property ((PROT_FAULT != 2'h0) [*3] |-> !FAULT_STATUS_LOW_PIN) else $error("fault pin high");
	a_load_gnd_ol:
	assert property (LOAD_GND_LOST[0] [*3] |-> OPENLOAD_FLAG[0]) else $error("no openload flag");
	a_sys_gnd_off:
	assert property (gnd_run_q >= 8'h3c && NEG_CLAMP_HIT == 2'h0 && !MON_RAW[MON_PWR_REV]
		|-> HIGH_SIDE_OUTPUTS == 2'h0) else $error("channels on after ground loss");
	a_neg_clamp_on:
	assert property ((NEG_CLAMP_HIT[0] && MON_RAW[7:6] == 2'h0) [*3] |-> HIGH_SIDE_OUTPUTS[0])
		else $error("clamp did not force channel on");
	a_fault_pin_high:
	assert property ((PROT_FAULT == 2'h0 && LOAD_GND_LOST == 2'h0 && OPENLOAD_RAW == 2'h0) [*2]
		|-> FAULT_STATUS_LOW_PIN) else $error("fault pin low without fault");
	a_retry_cnt_zero:
	assert property (RETRY_CLEAR |-> RETRY_CNT_OUT == 8'h00) else $error("retry count not cleared");
endmodule : sffc_top_props

bind sffc_top sffc_top_props sffc_top_props_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.MON_RAW(MON_RAW), .VDD_FAIL_EN(VDD_FAIL_EN), .DIRECT_IN(DIRECT_IN),
	.NEG_CLAMP_HIT(NEG_CLAMP_HIT), .LOAD_GND_LOST(LOAD_GND_LOST), .PROT_FAULT(PROT_FAULT),
	.OPENLOAD_RAW(OPENLOAD_RAW), .RETRY_CNT_OUT(RETRY_CNT_OUT),
	.HIGH_SIDE_OUTPUTS(HIGH_SIDE_OUTPUTS), .FAULT_STATUS_LOW_PIN(FAULT_STATUS_LOW_PIN),
	.SO_DATA_OE(SO_DATA_OE), .CURRENT_SENSE_EN(CURRENT_SENSE_EN), .REG_RESET(REG_RESET),
	.RETRY_CLEAR(RETRY_CLEAR), .OPENLOAD_FLAG(OPENLOAD_FLAG), .MODE_OUT(MODE_OUT));

// ### dv/test_sffc_top.sv
`timescale 1ns/1ps
module test_sffc_top
	import sffc_pkg::*;
;
	logic clk = 1'h0, rst_n = 1'h0, wake_req, en, so_d, so_en, current_sense_output, rr_seen, wake;
	logic fsl, fso, so_out, so_oe, cs_en, spi_en, rr, rc;
	logic [1:0] din, ch_on, neg, lgl, prot, olr, hs, olf;
	logic [7:0] mon, retry, st, rco;
	logic [2:0] mode;
	int fail_count = 0, samples_checked = 0, cycles = 0;
	always #12.5 clk = ~clk;
	sffc_top sffc_top_i (.CLK_SYS(clk), .RST_N(rst_n), .MON_RAW(mon),
		.RESET_WAKE_LOW_INPUT(wake), .DIRECT_IN(din), .VDD_FAIL_EN(en), .SPI_CH_ON(ch_on),
		.SPI_SO_DATA(so_d), .SPI_SO_EN(so_en), .CURRENT_SENSE_OUTPUT_REQ(current_sense_output), .NEG_CLAMP_HIT(neg),
		.LOAD_GND_LOST(lgl), .PROT_FAULT(prot), .OPENLOAD_RAW(olr), .RETRY_CNT_IN(retry),
		.HIGH_SIDE_OUTPUTS(hs), .FAULT_STATUS_LOW_PIN(fsl), .FAILSAFE_OUTPUT_LOW_PIN(fso),
		.SO_DATA_OUT(so_out), .SO_DATA_OE(so_oe), .CURRENT_SENSE_EN(cs_en),
		.SPI_ENABLE(spi_en), .REG_RESET(rr), .RETRY_CLEAR(rc), .OPENLOAD_FLAG(olf),
		.STATUS_REGISTER(st), .RETRY_CNT_OUT(rco), .MODE_OUT(mode));
	sffc_host_model sffc_host_model_i (.clk(clk), .wake_req(wake_req), .pwr_uv(mon[3]),
		.wake(wake));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cyc
	task automatic end_of_test();
		$display("checked %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		if (rr) rr_seen <= 1'h1;
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		mon = 8'h06;
		wake_req = 1;
		din = 0;
		en = 0;
		ch_on = 0;
		so_d = 1;
		so_en = 1;
		current_sense_output = 1;
		neg = 0;
		lgl = 0;
		prot = 0;
		olr = 0;
		retry = 8'h5a;
		rr_seen = 0;
		cyc(4);
		rst_n = 1;
		cyc(60);
		check(mode, MODE_NORMAL);
		check(fsl, 1'h1);
		check({so_oe, so_out, cs_en, spi_en}, 4'hf);
		check(rco, 8'h5a);
		mon[0] = 1;
		cyc(60);
		check(mode, MODE_NORMAL);
		check({so_oe, so_out, cs_en, st[0]}, 4'h1);
		mon[0] = 0;
		en = 1;
		din = 2'h2;
		cyc(60);
		mon[0] = 1;
		cyc(60);
		check(mode, MODE_FAILSAFE);
		check(fso, 1'h0);
		check(st[6], 1'h0);
		check(hs, 2'h2);
		din = 2'h1;
		cyc(3);
		check(hs, 2'h1);
		prot = 1;
		cyc(4);
		check(fsl, 1'h0);
		prot = 0;
		din = 0;
		mon[0] = 0;
		cyc(60);
		wake_req = 0;
		cyc(4);
		check(mode, MODE_SLEEP);
		wake_req = 1;
		cyc(4);
		check(mode, MODE_NORMAL);
		check(st[6], 1'h1);
		$display("test fail-safe done");
		rr_seen = 0;
		mon[2] = 0;
		cyc(50);
		mon[2] = 1;
		cyc(60);
		check(rr_seen, 1'h0);
		mon[2:1] = 0;
		cyc(50);
		mon[2] = 1;
		cyc(60);
		check(rr_seen, 1'h1);
		rr_seen = 0;
		mon[2] = 0;
		cyc(50);
		mon[1] = 1;
		cyc(60);
		check(rr_seen, 1'h1);
		mon[2] = 1;
		ch_on = 3;
		cyc(60);
		lgl = 2'h2;
		cyc(4);
		check({olf[1], hs}, 3'h7);
		check(fsl, 1'h0);
		lgl = 0;
		olr = 2'h1;
		cyc(4);
		check({olf, fsl}, 3'h2);
		olr = 0;
		ch_on = 0;
		neg = 1;
		cyc(4);
		check(hs, 2'h1);
		neg = 0;
		mon[5] = 1;
		cyc(60);
		check({st[5], hs}, 3'h7);
		mon[5] = 0;
		mon[4] = 1;
		cyc(60);
		check({st[4], spi_en}, 2'h3);
		mon[4] = 0;
		mon[3] = 1;
		cyc(60);
		check({wake, spi_en, st[3]}, 3'h7);
		mon[3] = 0;
		cyc(60);
		check(mode, MODE_NORMAL);
		ch_on = 3;
		mon[7] = 1;
		cyc(60);
		check({st[1], hs}, 3'h4);
		mon[7] = 0;
		cyc(60);
		mon[6] = 1;
		cyc(60);
		check({st[2], fso}, 2'h2);
		check(mode, MODE_FAILSAFE);
		$display("test supply and ground events done");
		end_of_test();
	end
endmodule : test_sffc_top
